// >>> rtl/vcc_pkg.sv
package vcc_pkg;
	// ************************************
	// register offsets (byte addresses)
	// ************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_LEAF      = 8'h04;
	localparam logic [7:0] OFS_MODE      = 8'h08;
	localparam logic [7:0] OFS_DS_LIMIT  = 8'h0C;
	localparam logic [7:0] OFS_TGT_LO    = 8'h10;
	localparam logic [7:0] OFS_TGT_HI    = 8'h14;
	localparam logic [7:0] OFS_PAR_LO    = 8'h18;
	localparam logic [7:0] OFS_PAR_HI    = 8'h1C;
	localparam logic [7:0] OFS_DS_BASE   = 8'h20;
	localparam logic [7:0] OFS_CACHE_PG  = 8'h24;
	localparam logic [7:0] OFS_MAP_SEL   = 8'h28;
	localparam logic [7:0] OFS_MAP_DATA  = 8'h2C;
	localparam logic [7:0] OFS_CNT_LO    = 8'h30;
	localparam logic [7:0] OFS_CNT_HI    = 8'h34;
	localparam logic [7:0] OFS_STATUS    = 8'h38;
	localparam logic [7:0] OFS_RESULT    = 8'h3C;
	localparam logic [7:0] OFS_FADDR_LO  = 8'h40;
	localparam logic [7:0] OFS_FADDR_HI  = 8'h44;
	localparam logic [7:0] OFS_FCODE     = 8'h48;
	localparam logic [7:0] OFS_FLAGS     = 8'h4C;

	// ************************************
	// leaf indices, codes, fields
	// ************************************
	localparam logic [31:0] LEAF_DEC      = 32'h0000_0000;
	localparam logic [31:0] LEAF_INC      = 32'h0000_0001;
	localparam logic [63:0] CODE_OK       = 64'h0;
	localparam logic [63:0] CODE_CONFLICT = 64'h1;
	localparam logic [63:0] CODE_BAD_CNT  = 64'h2;
	localparam logic [31:0] PF_ENCL_BIT   = 32'h0000_8000;
	localparam logic [31:0] GP_CODE       = 32'h0000_0000;
	localparam logic [1:0]  PRIV_KERNEL   = 2'h0;
	localparam int          PAGE_BITS     = 12;
	localparam int          ENTRIES       = 8;
	localparam int          IDX_W         = 3;
	// flag positions in the flags word
	localparam int F_CARRY  = 0;
	localparam int F_PARITY = 2;
	localparam int F_ADJUST = 4;
	localparam int F_ZERO   = 6;
	localparam int F_SIGN   = 7;
	localparam int F_OVFL   = 11;
	localparam logic [11:0] FLAG_MASK = 12'h8D5;
	localparam logic [11:0] ARITH_MASK = 12'h895;
	// map entry fields: valid 0, modifying 1, type 6:4, owner 10:8
	localparam logic [11:0] MAP_RST = 12'h000;

	typedef enum logic [2:0] {
		PT_CONTROL  = 3'h0,
		PT_REGULAR  = 3'h1,
		PT_THREAD   = 3'h2,
		PT_TRIMMED  = 3'h3,
		SHADOW_STACK_FIRST_TYPE = 3'h4,
		SHADOW_STACK_REST_TYPE  = 3'h5
	} vcc_ptype_t;

	typedef enum logic [1:0] {
		FK_NONE = 2'h0,
		FK_GP   = 2'h1,
		FK_PF   = 2'h2,
		FK_PRIV = 2'h3
	} vcc_fault_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_CHECK   = 4'b0010,
		ST_DECR    = 4'b0100,
		ST_RESTORE = 4'b1000
	} vcc_state_t;
endpackage

// >>> rtl/vcc_leaf.sv
`timescale 1ns/10ps
// Behaviour
// - leaf index 00H selects the decrement leaf
// - decrement leaf only at privilege level 0
// - leaf index 01H selects increment, adds one
// - increment leaf only at privilege level 0
// - operands addressed via data segment only
// - unaligned target page gives protection fault 0
// - target outside page cache: page fault
// - parent outside page cache: page fault
// - target being modified: conflict code, zero set
// - invalid map entry gives target page fault
// - child types use owner; types other than child or control fault
// - control page target is its own parent
// - parent mismatch gives protection fault 0
// - locked decrement with underflow detection
// - underflow restores count, invalid counter code
// - count and parent address held 64 bits
// - success clears zero flag, result zero
// - every completion without a fault clears carry,parity,adjust,overflow,sign
// - 32-bit mode: limit or unusable segment faults
// - 64-bit mode: non-canonical address faults
// - memory access page faults reported as such
// - parent concurrent, target shared with conflict
module vcc_leaf
	import vcc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// all checks below share this clock and reset
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ************************************
	// bus slave
	// ************************************
	logic [7:0]  aw_addr;
	logic        aw_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_full;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        rvalid;
	logic [1:0]  rresp;
	logic [31:0] rdata;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire  = s_axi_wvalid & s_axi_wready;
	wire wr_go   = aw_full & w_full & ~bvalid;
	wire ar_fire = s_axi_arvalid & s_axi_arready;

	assign s_axi_awready = ~aw_full & ~bvalid;
	assign s_axi_wready  = ~w_full & ~bvalid;
	assign s_axi_arready = ~rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = rdata;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ************************************
	// software registers
	// ************************************
	logic [31:0]       leaf;
	logic [1:0]        cpl;
	logic              mode64;
	logic              ds_unusable;
	logic [31:0]       ds_limit;
	logic [63:0]       tgt_ea;
	logic [63:0]       par_ea;
	logic [31:0]       ds_base;
	logic [31:0]       cache_pg;
	logic [IDX_W-1:0]  map_sel;
	logic [11:0]       map_word [ENTRIES];
	logic [63:0]       cnt [ENTRIES];
	logic [11:0]       flags;
	logic [63:0]       result;
	vcc_fault_t        fault;
	logic [63:0]       fault_addr;
	logic [31:0]       fault_code;
	logic              done;
	vcc_state_t        state;

	wire wsel_ctrl  = wr_go & (aw_addr == OFS_CTRL);
	wire wsel_cnlo  = wr_go & (aw_addr == OFS_CNT_LO);
	wire wsel_cnhi  = wr_go & (aw_addr == OFS_CNT_HI);
	wire wsel_map   = wr_go & (aw_addr == OFS_MAP_DATA);
	wire wsel_flags = wr_go & (aw_addr == OFS_FLAGS);
	wire idle       = (state == ST_IDLE);
	// operands freeze while a leaf runs
	wire wr_cfg     = wr_go & idle;
	wire start      = wsel_ctrl & w_strb[0] & w_data[0] & idle;
	wire wr_known   = (aw_addr <= OFS_FLAGS) & (aw_addr[1:0] == 2'b00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= 2'b00;
		end else begin
			if (aw_fire) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_known ? 2'b00 : 2'b10;
			end else if (bvalid && s_axi_bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			leaf        <= 32'h0;
			cpl         <= 2'h0;
			mode64      <= 1'b0;
			ds_unusable <= 1'b0;
			ds_limit    <= 32'hFFFF_FFFF;
			tgt_ea      <= 64'h0;
			par_ea      <= 64'h0;
			ds_base     <= 32'h0;
			cache_pg    <= 32'h0;
			map_sel     <= '0;
		end else if (wr_cfg) begin
			unique case (aw_addr)
				OFS_LEAF:     leaf <= merge(leaf, w_data, w_strb);
				OFS_MODE: begin
					if (w_strb[0]) begin
						cpl         <= w_data[1:0];
						mode64      <= w_data[2];
						ds_unusable <= w_data[3];
					end
				end
				OFS_DS_LIMIT: ds_limit <= merge(ds_limit, w_data, w_strb);
				OFS_TGT_LO:   tgt_ea[31:0] <= merge(tgt_ea[31:0], w_data, w_strb);
				OFS_TGT_HI:   tgt_ea[63:32] <= merge(tgt_ea[63:32], w_data,
					w_strb);
				OFS_PAR_LO:   par_ea[31:0] <= merge(par_ea[31:0], w_data, w_strb);
				OFS_PAR_HI:   par_ea[63:32] <= merge(par_ea[63:32], w_data,
					w_strb);
				OFS_DS_BASE:  ds_base <= merge(ds_base, w_data, w_strb);
				OFS_CACHE_PG: cache_pg <= merge(cache_pg, w_data, w_strb);
				OFS_MAP_SEL: begin
					if (w_strb[0]) begin
						map_sel <= w_data[IDX_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// ************************************
	// operand address formation
	// ************************************
	// data segment only; no override input exists at all
	wire [63:0] tgt_lin = mode64 ? tgt_ea :
		{32'h0, ds_base + tgt_ea[31:0]};
	wire [63:0] par_lin = mode64 ? par_ea :
		{32'h0, ds_base + par_ea[31:0]};
	wire seg32_bad = ~mode64 & (ds_unusable | (tgt_ea[31:0] > ds_limit) |
		(par_ea[31:0] > ds_limit));
	wire tgt_canon = (&tgt_ea[63:47]) | ~(|tgt_ea[63:47]);
	wire par_canon = (&par_ea[63:47]) | ~(|par_ea[63:47]);
	wire canon_bad = mode64 & ~(tgt_canon & par_canon);
	wire unaligned = |tgt_lin[PAGE_BITS-1:0];

	// page cache is ENTRIES pages starting at cache_pg
	wire [51:0] tgt_off = tgt_lin[63:PAGE_BITS] - {20'h0, cache_pg};
	wire [51:0] par_off = par_lin[63:PAGE_BITS] - {20'h0, cache_pg};
	wire tgt_hit = tgt_off < 52'(ENTRIES);
	wire par_hit = par_off < 52'(ENTRIES);
	wire [IDX_W-1:0] tgt_idx = tgt_off[IDX_W-1:0];
	wire [IDX_W-1:0] par_idx = par_off[IDX_W-1:0];

	wire [11:0]      tgt_map   = map_word[tgt_idx];
	wire             tgt_valid = tgt_map[0];
	// shared access on target: clash while it is being modified
	wire             tgt_busy  = tgt_map[1];
	wire [2:0]       tgt_type  = tgt_map[6:4];
	wire [IDX_W-1:0] tgt_owner = tgt_map[8 +: IDX_W];

	wire type_child = (tgt_type == PT_REGULAR) | (tgt_type == PT_THREAD) |
		(tgt_type == PT_TRIMMED) | (tgt_type == SHADOW_STACK_FIRST_TYPE) |
		(tgt_type == SHADOW_STACK_REST_TYPE);
	wire type_ctrl  = (tgt_type == PT_CONTROL);
	wire [63:0] owner_pa = {20'h0, cache_pg + 32'(tgt_owner), 12'h000};
	wire [63:0] own_pa = {tgt_lin[63:PAGE_BITS], 12'h000};
	wire [63:0] next_parent = type_ctrl ? own_pa : owner_pa;
	wire par_match = (next_parent == {par_lin[63:PAGE_BITS], 12'h000});
	// counter operand lives in the derived parent's entry
	wire [IDX_W-1:0] cnt_idx = type_ctrl ? tgt_idx : tgt_owner;

	wire leaf_dec = (leaf == LEAF_DEC);
	wire leaf_inc = (leaf == LEAF_INC);
	wire priv_ok  = (cpl == PRIV_KERNEL);

	// ************************************
	// ordered check chain
	// ************************************
	// first failing step wins; later ones are masked off
	vcc_fault_t  chk_fault;
	logic [63:0] chk_addr;
	logic [31:0] chk_code;
	logic        chk_conflict;
	always_comb begin
		chk_fault    = FK_NONE;
		chk_addr     = 64'h0;
		chk_code     = GP_CODE;
		chk_conflict = 1'b0;
		if (!(leaf_dec || leaf_inc) || !priv_ok) begin
			chk_fault = FK_PRIV;
		end else if (seg32_bad || canon_bad) begin
			chk_fault = FK_GP;
		end else if (unaligned) begin
			chk_fault = FK_GP;
		end else if (!tgt_hit) begin
			chk_fault = FK_PF;
			chk_addr  = tgt_lin;
			chk_code  = PF_ENCL_BIT;
		end else if (!par_hit) begin
			chk_fault = FK_PF;
			chk_addr  = par_lin;
			chk_code  = PF_ENCL_BIT;
		end else if (tgt_busy) begin
			chk_conflict = 1'b1;
		end else if (!tgt_valid || !(type_child || type_ctrl)) begin
			chk_fault = FK_PF;
			chk_addr  = tgt_lin;
			chk_code  = PF_ENCL_BIT;
		end else if (!par_match) begin
			chk_fault = FK_GP;
		end
	end

	// ************************************
	// sequencer
	// ************************************
	logic [63:0]      parent_pa;
	logic [IDX_W-1:0] op_idx;
	logic [63:0]      cnt_tmp;
	wire  chk_pass = (chk_fault == FK_NONE) & ~chk_conflict;
	wire  underflow = (cnt_tmp == 64'h0);
	// fsm write port to the count array
	// only the increment leaf writes from the check step
	wire              fsm_wr = (state == ST_CHECK & chk_pass & leaf_inc) |
		(state == ST_DECR) | (state == ST_RESTORE);
	wire [IDX_W-1:0]  fsm_idx = (state == ST_CHECK) ? cnt_idx : op_idx;
	wire [63:0]       cur_cnt = cnt[fsm_idx];
	wire [63:0]       next_cnt = (state == ST_DECR) ? cur_cnt - 64'h1 :
		cur_cnt + 64'h1;
	wire              finish = (state == ST_CHECK & ~chk_pass) |
		(state == ST_CHECK & leaf_inc) | (state == ST_DECR) |
		(state == ST_RESTORE);
	wire              complete = finish & ~(state == ST_DECR & underflow) &
		(chk_fault == FK_NONE | state != ST_CHECK);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state      <= ST_IDLE;
			parent_pa  <= 64'h0;
			op_idx     <= '0;
			cnt_tmp    <= 64'h0;
			fault      <= FK_NONE;
			fault_addr <= 64'h0;
			fault_code <= 32'h0;
			done       <= 1'b0;
			result     <= 64'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_CHECK;
						done  <= 1'b0;
						fault <= FK_NONE;
					end
				end
				ST_CHECK: begin
					parent_pa  <= next_parent;
					op_idx     <= cnt_idx;
					cnt_tmp    <= cur_cnt;
					fault      <= chk_fault;
					fault_addr <= chk_addr;
					fault_code <= chk_code;
					if (chk_pass && leaf_dec) begin
						state <= ST_DECR;
					end else begin
						state <= ST_IDLE;
						done  <= 1'b1;
					end
					if (chk_conflict) begin
						result <= CODE_CONFLICT;
					end else if (chk_pass) begin
						result <= CODE_OK;
					end
				end
				ST_DECR: begin
					// decrement and restore run back to back, no bus
					// write can reach the count in between
					if (underflow) begin
						state <= ST_RESTORE;
					end else begin
						state  <= ST_IDLE;
						done   <= 1'b1;
						result <= CODE_OK;
					end
				end
				ST_RESTORE: begin
					state  <= ST_IDLE;
					done   <= 1'b1;
					result <= CODE_BAD_CNT;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// zero flag: set for conflict or underflow only
	wire zf_set = (state == ST_CHECK & chk_conflict) |
		(state == ST_RESTORE);
	wire [11:0] done_flags = (flags & ~FLAG_MASK) |
		({11'h0, zf_set} << F_ZERO);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= 12'h0;
		end else if (complete) begin
			flags <= done_flags;
		end else if (wsel_flags && idle) begin
			flags <= 12'(merge({20'h0, flags}, w_data, w_strb)) &
				FLAG_MASK;
		end
	end

	// ************************************
	// page cache map and counts
	// ************************************
	wire [63:0] sel_cnt = cnt[map_sel];
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_ent
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					map_word[g] <= MAP_RST;
					cnt[g]      <= 64'h0;
				end else begin
					if (wsel_map && idle && map_sel == IDX_W'(g)) begin
						map_word[g] <= 12'(merge({20'h0, map_word[g]},
							w_data, w_strb));
					end
					if (fsm_wr && (state != ST_DECR || !underflow) &&
						fsm_idx == IDX_W'(g)) begin
						cnt[g] <= next_cnt;
					end else if (fsm_wr && state == ST_DECR &&
						fsm_idx == IDX_W'(g)) begin
						cnt[g] <= next_cnt;
					end else if (idle && map_sel == IDX_W'(g)) begin
						if (wsel_cnlo) begin
							cnt[g][31:0] <= merge(cnt[g][31:0], w_data,
								w_strb);
						end else if (wsel_cnhi) begin
							cnt[g][63:32] <= merge(cnt[g][63:32], w_data,
								w_strb);
						end
					end
				end
			end
		end
	endgenerate

	// ************************************
	// read path
	// ************************************
	wire [31:0] status = {26'h0, fault, 2'b00, done, ~idle};
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			OFS_CTRL:     rd_mux = 32'h0;
			OFS_LEAF:     rd_mux = leaf;
			OFS_MODE:     rd_mux = {28'h0, ds_unusable, mode64, cpl};
			OFS_DS_LIMIT: rd_mux = ds_limit;
			OFS_TGT_LO:   rd_mux = tgt_ea[31:0];
			OFS_TGT_HI:   rd_mux = tgt_ea[63:32];
			OFS_PAR_LO:   rd_mux = par_ea[31:0];
			OFS_PAR_HI:   rd_mux = par_ea[63:32];
			OFS_DS_BASE:  rd_mux = ds_base;
			OFS_CACHE_PG: rd_mux = cache_pg;
			OFS_MAP_SEL:  rd_mux = {29'h0, map_sel};
			OFS_MAP_DATA: rd_mux = {20'h0, map_word[map_sel]};
			OFS_CNT_LO:   rd_mux = sel_cnt[31:0];
			OFS_CNT_HI:   rd_mux = sel_cnt[63:32];
			OFS_STATUS:   rd_mux = status;
			OFS_RESULT:   rd_mux = result[31:0];
			OFS_FADDR_LO: rd_mux = fault_addr[31:0];
			OFS_FADDR_HI: rd_mux = fault_addr[63:32];
			OFS_FCODE:    rd_mux = fault_code;
			OFS_FLAGS:    rd_mux = {20'h0, flags};
			default: begin
				rd_mux = 32'h0;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= 2'b00;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= rd_ok ? 2'b00 : 2'b10;
		end else if (rvalid && s_axi_rready) begin
			rvalid <= 1'b0;
		end
	end

	// ************************************
	// checks
	// ************************************
	chk_priv_refuse: assert property (
		state == ST_CHECK && !priv_ok |=> fault == FK_PRIV && idle)
		else $error("unprivileged leaf not refused");
	chk_align_fault: assert property (
		state == ST_CHECK && priv_ok && (leaf_dec || leaf_inc) &&
		!seg32_bad && !canon_bad && unaligned |=> fault == FK_GP)
		else $error("unaligned target without protection fault");
	chk_conflict_code: assert property (
		state == ST_CHECK && chk_conflict |=>
		result == CODE_CONFLICT && flags[F_ZERO] && done)
		else $error("conflict not reported");
	chk_underflow_keep: assert property (
		state == ST_DECR && underflow |=> state == ST_RESTORE ##1
		(cnt[op_idx] == 64'h0 && result == CODE_BAD_CNT))
		else $error("underflow not restored");
	chk_dec_value: assert property (
		state == ST_DECR && !underflow |=>
		cnt[op_idx] == $past(cnt_tmp) - 64'h1)
		else $error("count not decremented by one");
	chk_success_zero: assert property (
		state == ST_DECR && !underflow |=> result == CODE_OK &&
		!flags[F_ZERO])
		else $error("success not reported");
	chk_arith_clear: assert property (
		complete |=> (flags & ARITH_MASK) == 12'h0)
		else $error("arithmetic flags not cleared");
	chk_parent_gp: assert property (
		state == ST_CHECK && chk_fault == FK_GP && tgt_hit && par_hit &&
		!unaligned |=> fault_code == GP_CODE && result == $past(result))
		else $error("mismatch fault altered result");
	chk_start_seq: assert property (
		start |=> state == ST_CHECK ##[1:3] idle)
		else $error("leaf did not finish in bound");
endmodule

// >>> tb/vcc_leaf_tb.sv
`timescale 1ns/10ps
module vcc_leaf_tb;
	import vcc_pkg::*;
	// ************************************
	// bus signals and counters
	// ************************************
	logic        aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r;
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [7:0]  aw_a, ar_a;
	logic [31:0] w_d, r_d, rd;
	logic [3:0]  w_s;
	logic [1:0]  b_resp, r_resp, rs, bs;
	int          bad_count, checks;

	vcc_leaf u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(r_r));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ************************************
	// shared tasks
	// ************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	// readies are sampled at the falling edge; the next rise takes the item
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, wd, ah, wh;
		int n;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (n = 0; n < 20 && !(ad && wd); n++) begin
			@(negedge aclk);
			ah = aw_v && aw_rdy;
			wh = w_v && w_rdy;
			@(posedge aclk);
			if (ah) aw_v <= 1'b0;
			if (wh) w_v <= 1'b0;
			ad = ad | ah;
			wd = wd | wh;
		end
		chk("aw_w_taken", 32'h1, {31'h0, ad & wd});
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			if (b_v) break;
		end
		chk("b_wait", 32'h1, {31'h0, b_v});
		bs = b_resp;
		@(posedge aclk);
		b_r <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			if (ar_rdy) break;
		end
		chk("ar_wait", 32'h1, {31'h0, ar_rdy});
		@(posedge aclk);
		ar_v <= 1'b0;
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			if (r_v) break;
		end
		chk("r_wait", 32'h1, {31'h0, r_v});
		rd = r_d;
		rs = r_resp;
		@(posedge aclk);
		r_r <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input string n,
		input logic [31:0] e);
		rdr(a);
		chk(n, e, rd);
	endtask

	// start is only sent when idle; poll for done with busy low
	task automatic leaf(input logic [31:0] l, m, t, p, th);
		int n;
		wr(OFS_LEAF, l);
		wr(OFS_MODE, m);
		wr(OFS_TGT_LO, t);
		wr(OFS_TGT_HI, th);
		wr(OFS_PAR_LO, p);
		wr(OFS_CTRL, 32'h0000_0001);
		for (n = 0; n < 20; n++) begin
			rdr(OFS_STATUS);
			if (rd[1:0] === 2'b10) break;
		end
		chk("busy_wait", 32'h2, {30'h0, rd[1:0]});
	endtask

	task automatic res(input logic [31:0] r, f);
		rchk(OFS_STATUS, "status", 32'h0000_0002);
		rchk(OFS_RESULT, "result", r);
		rchk(OFS_FLAGS, "flags", f);
	endtask

	task automatic setcnt(input logic [31:0] lo, hi);
		wr(OFS_MAP_SEL, 32'h0000_0000);
		wr(OFS_CNT_LO, lo);
		wr(OFS_CNT_HI, hi);
	endtask

	// ************************************
	// scenarios
	// ************************************
	task automatic t_setup();
		rchk(OFS_DS_LIMIT, "limit", 32'hFFFF_FFFF);
		rdr(8'h50);
		chk("unmapped", 32'h0000_0002, {30'h0, rs});
		wr(8'h50, 32'h0);
		chk("wr_unmapped", 32'h0000_0002, {30'h0, bs});
		wr(OFS_CACHE_PG, 32'h0000_0100);
		chk("wr_okay", 32'h0, {30'h0, bs});
		wr(OFS_MAP_SEL, 32'h0000_0001);
		wr(OFS_MAP_DATA, 32'h0000_0011);
		wr(OFS_MAP_SEL, 32'h0000_0003);
		wr(OFS_MAP_DATA, 32'h0000_0061);
		wr(OFS_MAP_SEL, 32'h0000_0000);
		wr(OFS_MAP_DATA, 32'h0000_0001);
	endtask

	task automatic t_dec();
		setcnt(32'h0000_0001, 32'h0);
		wr(OFS_FLAGS, 32'h0000_08D5);
		leaf(LEAF_DEC, 32'h0, 32'h0010_1000, 32'h0010_0000, 32'h0);
		res(32'h0, 32'h0);
		rchk(OFS_CNT_LO, "cnt", 32'h0);
		wr(OFS_FLAGS, 32'h0000_0895);
		leaf(LEAF_DEC, 32'h0, 32'h0010_1000, 32'h0010_0000, 32'h0);
		res(32'h0000_0002, 32'h0000_0040);
		rchk(OFS_CNT_LO, "cnt_lo", 32'h0);
		rchk(OFS_CNT_HI, "cnt_hi", 32'h0);
	endtask

	// carry across the word boundary shows the full 64-bit count
	task automatic t_wide();
		setcnt(32'hFFFF_FFFF, 32'h0);
		leaf(LEAF_INC, 32'h0, 32'h0010_0000, 32'h0010_0000, 32'h0);
		res(32'h0, 32'h0);
		rchk(OFS_CNT_HI, "inc_hi", 32'h0000_0001);
		leaf(LEAF_DEC, 32'h0, 32'h0010_1000, 32'h0010_0000, 32'h0);
		rchk(OFS_CNT_LO, "dec_lo", 32'hFFFF_FFFF);
		rchk(OFS_CNT_HI, "dec_hi", 32'h0);
	endtask

	task automatic t_conflict();
		wr(OFS_MAP_SEL, 32'h0000_0001);
		wr(OFS_MAP_DATA, 32'h0000_0013);
		wr(OFS_FLAGS, 32'h0000_08D5);
		leaf(LEAF_DEC, 32'h0, 32'h0010_1000, 32'h0010_0000, 32'h0);
		res(32'h0000_0001, 32'h0000_0040);
		wr(OFS_MAP_DATA, 32'h0000_0012);
		leaf(LEAF_DEC, 32'h0, 32'h0010_1000, 32'h0010_0000, 32'h0);
		rchk(OFS_RESULT, "conf_first", 32'h0000_0001);
		wr(OFS_MAP_DATA, 32'h0000_0011);
		wr(OFS_MAP_SEL, 32'h0000_0000);
		rchk(OFS_CNT_LO, "conf_cnt", 32'hFFFF_FFFF);
	endtask

	task automatic t_seg();
		wr(OFS_DS_BASE, 32'h0000_1000);
		leaf(LEAF_DEC, 32'h0, 32'h0010_0000, 32'h000F_F000, 32'h0);
		rchk(OFS_STATUS, "seg32", 32'h0000_0002);
		leaf(LEAF_DEC, 32'h4, 32'h0010_1000, 32'h0010_0000, 32'h0);
		rchk(OFS_STATUS, "seg64", 32'h0000_0002);
		wr(OFS_DS_BASE, 32'h0);
	endtask

	// one row per bad operand; the count must survive every fault
	task automatic t_faults();
		logic [3:0]  lf [13] = '{4'h2, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0,
			4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
		logic [3:0]  md [13] = '{4'h0, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0,
			4'h0, 4'h0, 4'h8, 4'h4, 4'h0, 4'h0};
		logic [23:0] tg [13] = '{24'h101000, 24'h101000, 24'h101000,
			24'h101004, 24'h200000, 24'h101000, 24'h102000, 24'h103000,
			24'h101000, 24'h101000, 24'h101000, 24'h200004, 24'h200000};
		logic [1:0]  fk [13] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h2, 2'h2,
			2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
		logic [31:0] pr, fa;
		for (int i = 0; i < 13; i++) begin
			pr = (i == 5) ? 32'h0030_0000 : (i == 8) ? 32'h0010_3000 :
				32'h0010_0000;
			fa = (i == 5) ? pr : {8'h0, tg[i]};
			leaf({28'h0, lf[i]}, {28'h0, md[i]}, {8'h0, tg[i]}, pr,
				(i == 10) ? 32'h0000_8000 : 32'h0);
			rchk(OFS_STATUS, "fault", {26'h0, fk[i], 4'h2});
			if (fk[i] == 2'h2) begin
				rchk(OFS_FCODE, "pf_code", PF_ENCL_BIT);
				rchk(OFS_FADDR_LO, "pf_addr", fa);
			end
			if (fk[i] == 2'h1)
				rchk(OFS_FCODE, "gp_code", GP_CODE);
		end
		rchk(OFS_CNT_LO, "kept", 32'hFFFF_FFFD);
	endtask

	// ************************************
	// main sequence and watchdog
	// ************************************
	initial begin
		aresetn = 1'b0;
		{aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
		aw_a = 8'h00;
		ar_a = 8'h00;
		w_d = 32'h0;
		w_s = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_setup();
		t_dec();
		t_wide();
		t_conflict();
		t_seg();
		t_faults();
		print_verdict();
	end

	// the run needs under a thousand cycles; this is far beyond that
	initial begin
		#400000;
		bad_count++;
		print_verdict();
	end
endmodule
